/* File: pkg/hbgp_pkg.sv */
package hbgp_pkg;
	// pci bus commands used by this master
	localparam logic [3:0] CMD_MEM_READ  = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	// byte enables, all lanes active low
	localparam logic [3:0] BE_ALL_N      = 4'h0;
	// medium decode: devsel sampled on the second clock after address
	localparam logic [2:0] DEVSEL_MED    = 3'h2;
	// master abort if no devsel by this count of link clocks
	localparam logic [2:0] DEVSEL_LIMIT  = 3'h5;
	// status bus code meaning a pci-style grant to the master
	localparam logic [2:0] ST_PCI_GRANT  = 3'h7;
	// gfx sideband command width
	localparam int         SBA_W         = 8;
	// link states
	typedef enum logic [2:0] {
		HBGP_IDLE, HBGP_REQ, HBGP_ADDR, HBGP_DATA, HBGP_TURN
	} hbgp_state_t;
endpackage

/* File: pkg/hbgp_req_if.sv */
`timescale 1ns/1ps
// request/answer pair crossing between system and link domains
interface hbgp_req_if;
	logic        toggle;	// flips once per request
	logic        write;	// 1 = write
	logic [31:0] addr;	// target address
	logic [31:0] wdata;	// write data
	logic        done_toggle;	// flips once per completion
	logic [31:0] rdata;	// read data
	logic        error;	// stopped or master abort
	modport sys  (output toggle, write, addr, wdata, input done_toggle, rdata, error);
	modport link (input toggle, write, addr, wdata, output done_toggle, rdata, error);
endinterface

/* File: logic/hbgp_sync.sv */
`timescale 1ns/1ps
// two-flop level synchroniser
module hbgp_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// level in and out
	input  wire logic d,
	output logic      q
);
	logic meta_reg;	// first stage, read only by q
	// plain two stage chain
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* File: logic/hbgp_master.sv */
`timescale 1ns/1ps
// What this block does
// (RQ1) gfx stop acts as pci stop
// (RQ2) graphics master requests graphics port
// (RQ3) grant with pci meaning plus status
// (RQ4) parity over address/data and command lines
// (RQ5) pipe presents one address per edge; here gfx_pipe_n is held high, no pipelined requests
// (RQ6) sideband bus carries address and commands; here gfx_sideband is held idle at 8'h00
// (RQ7) read buffer full gates low-priority data; here gfx_read_full_n is tied high, never full
// (RQ8) status meaningful only while granted
// (RQ9) data agent drives both strobes identically; here both strobes are held low with gfx_strobe_oe low, undriven
// (RQ10) master drives sideband strobe; here gfx_sideband_strobe is held low, sideband unused
// (RQ11) address with frame, data afterwards
// (RQ12) command with frame, then byte enables
// (RQ13) frame marks address; drop before last
// (RQ14) bridge claims dram with medium devsel
// (RQ15) irdy only when initiator ready
// (RQ16) trdy only when target ready
// (RQ17) stop from target ends transaction
// (RQ18) no locked cycles from pci initiators
// (RQ19) each pci master has request line
// (RQ20) pci reset tri-states pci outputs
// (RQ21) at most one grant at once
module hbgp_master (
	// system side
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_write,
	input  wire logic [31:0] cmd_addr,
	input  wire logic [31:0] cmd_wdata,
	output logic             rsp_valid,
	output logic [31:0]      rsp_rdata,
	output logic             rsp_error,
	// link clock
	input  wire logic        clk_link,
	// gfx port pins
	output logic             gfx_request_n,
	input  wire logic        gfx_grant_n,
	input  wire logic [2:0]  gfx_status,
	output logic             gfx_pipe_n,
	output logic [7:0]       gfx_sideband,
	output logic             gfx_sideband_strobe,
	output logic             gfx_read_full_n,
	output logic             gfx_strobe_a,
	output logic             gfx_strobe_b,
	output logic             gfx_strobe_oe,
	// pci-style bus pins, three signals each where two-way
	input  wire logic [31:0] ad_in,
	output logic [31:0]      ad_out,
	output logic             ad_oe,
	output logic [3:0]       cbe_out_n,
	output logic             cbe_oe,
	output logic             par_out,
	output logic             par_oe,
	input  wire logic        frame_in_n,
	output logic             frame_out_n,
	output logic             frame_oe,
	output logic             irdy_out_n,
	output logic             irdy_oe,
	input  wire logic        trdy_in_n,
	input  wire logic        devsel_in_n,
	input  wire logic        stop_in_n,
	output logic             lock_out_n,
	output logic             lock_oe,
	output logic             pci_reset_n
);
	hbgp_req_if xfer ();	// carries one request across the domains
	// ---------------- system domain ----------------
	logic busy_reg;	// request outstanding
	logic done_sync;	// synchronised completion toggle
	logic done_seen_reg;	// last completion toggle seen
	logic toggle_reg;	// request toggle
	logic write_reg;	// held request fields
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	hbgp_sync u_done_sync (
		.clk     (clk_sys),
		.reset_n (reset_n),
		.d       (xfer.done_toggle),
		.q       (done_sync)
	);
	assign cmd_ready = !busy_reg;
	assign xfer.toggle = toggle_reg;
	assign xfer.write  = write_reg;
	assign xfer.addr   = addr_reg;
	assign xfer.wdata  = wdata_reg;
	// accept one command, hold fields stable until done
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			busy_reg      <= 1'b0;
			toggle_reg    <= 1'b0;
			write_reg     <= 1'b0;
			addr_reg      <= 32'h0000_0000;
			wdata_reg     <= 32'h0000_0000;
			done_seen_reg <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp_rdata     <= 32'h0000_0000;
			rsp_error     <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (cmd_valid && !busy_reg) begin
				busy_reg   <= 1'b1;
				write_reg  <= cmd_write;
				addr_reg   <= cmd_addr;
				wdata_reg  <= cmd_wdata;
				toggle_reg <= !toggle_reg;
			end
			// rdata/error are stable once the toggle is seen here
			if (busy_reg && done_sync != done_seen_reg) begin
				done_seen_reg <= done_sync;
				busy_reg      <= 1'b0;
				rsp_valid     <= 1'b1;
				rsp_rdata     <= xfer.rdata;
				rsp_error     <= xfer.error;
			end
		end
	end
	// ---------------- link domain ----------------
	logic link_rst_meta_reg;	// reset sync into link clock
	logic link_rst_n_reg;
	always_ff @(posedge clk_link) begin
		if (!reset_n) begin
			link_rst_meta_reg <= 1'b0;
			link_rst_n_reg    <= 1'b0;
		end else begin
			link_rst_meta_reg <= 1'b1;
			link_rst_n_reg    <= link_rst_meta_reg;
		end
	end
	logic req_sync;	// synchronised request toggle
	logic req_seen_reg;
	logic grant_s, trdy_s, devsel_s, stop_s;	// synchronised inputs, high when asserted
	logic frame_busy_s;	// some master holds frame
	logic [2:0] status_s;
	hbgp_sync u_req  (.clk(clk_link), .reset_n(link_rst_n_reg), .d(xfer.toggle), .q(req_sync));
	hbgp_sync u_gnt  (.clk(clk_link), .reset_n(link_rst_n_reg), .d(!gfx_grant_n),
		.q(grant_s));
	hbgp_sync u_trdy (.clk(clk_link), .reset_n(link_rst_n_reg), .d(!trdy_in_n), .q(trdy_s));
	hbgp_sync u_dev  (.clk(clk_link), .reset_n(link_rst_n_reg), .d(!devsel_in_n),
		.q(devsel_s));
	hbgp_sync u_stop (.clk(clk_link), .reset_n(link_rst_n_reg), .d(!stop_in_n), .q(stop_s));
	// frame is a pin too, so the idle test reads it only after two flops
	hbgp_sync u_frm  (.clk(clk_link), .reset_n(link_rst_n_reg), .d(!frame_in_n),
		.q(frame_busy_s));
	// status bits pass through a generate of syncs
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_st
			hbgp_sync u_st (.clk(clk_link), .reset_n(link_rst_n_reg), .d(gfx_status[gi]),
				.q(status_s[gi]));
		end
	endgenerate
	// synchronised pins read high while the pin is asserted
	hbgp_pkg::hbgp_state_t state_reg;
	logic [2:0]  wait_reg;	// devsel wait counter
	logic        done_tog_reg;
	logic [31:0] rdata_reg;
	logic        err_reg;
	assign xfer.done_toggle = done_tog_reg;
	assign xfer.rdata       = rdata_reg;
	assign xfer.error       = err_reg;
	// (RQ8) grant with usable status
	logic granted;
	assign granted = grant_s && (status_s == hbgp_pkg::ST_PCI_GRANT);
	// (RQ4) parity over address/data and command
	logic par_next;
	assign par_next = ^{ad_out, cbe_out_n};
	// main link transaction sequencer
	always_ff @(posedge clk_link) begin
		if (!link_rst_n_reg) begin
			state_reg     <= hbgp_pkg::HBGP_IDLE;
			req_seen_reg  <= 1'b0;
			wait_reg      <= 3'h0;
			done_tog_reg  <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			err_reg       <= 1'b0;
			gfx_request_n <= 1'b1;
			ad_out        <= 32'h0000_0000;
			ad_oe         <= 1'b0;
			cbe_out_n     <= 4'hF;
			cbe_oe        <= 1'b0;
			frame_out_n   <= 1'b1;
			frame_oe      <= 1'b0;
			irdy_out_n    <= 1'b1;
			irdy_oe       <= 1'b0;
		end else begin
			unique case (state_reg)
				hbgp_pkg::HBGP_IDLE: begin
					if (req_sync != req_seen_reg) begin
						req_seen_reg <= req_sync;
						// (RQ2) (RQ19) own request line
						gfx_request_n <= 1'b0;
						state_reg     <= hbgp_pkg::HBGP_REQ;
					end
				end
				hbgp_pkg::HBGP_REQ: begin
					// (RQ3) start only on pci-style grant
					if (granted && !frame_busy_s) begin
						// (RQ11) address driven with frame
						ad_out      <= xfer.addr;
						ad_oe       <= 1'b1;
						cbe_out_n   <= xfer.write ? hbgp_pkg::CMD_MEM_WRITE
							: hbgp_pkg::CMD_MEM_READ;
						cbe_oe      <= 1'b1;
						// (RQ13) single data phase: frame one clock
						frame_out_n <= 1'b0;
						frame_oe    <= 1'b1;
						wait_reg    <= 3'h0;
						state_reg   <= hbgp_pkg::HBGP_ADDR;
					end
				end
				hbgp_pkg::HBGP_ADDR: begin
					gfx_request_n <= 1'b1;
					// (RQ13) deassert frame before last data
					frame_out_n   <= 1'b1;
					// (RQ12) byte enables follow command
					cbe_out_n     <= hbgp_pkg::BE_ALL_N;
					ad_out        <= xfer.wdata;
					ad_oe         <= xfer.write;
					// (RQ15) irdy only when data ready
					irdy_out_n    <= 1'b0;
					irdy_oe       <= 1'b1;
					state_reg     <= hbgp_pkg::HBGP_DATA;
				end
				hbgp_pkg::HBGP_DATA: begin
					wait_reg <= wait_reg + 3'h1;
					// (RQ16) complete on target ready
					if (trdy_s) begin
						rdata_reg <= ad_in;
						err_reg   <= 1'b0;
						state_reg <= hbgp_pkg::HBGP_TURN;
					// (RQ1) (RQ17) target stop ends it
					end else if (stop_s) begin
						err_reg   <= 1'b1;
						state_reg <= hbgp_pkg::HBGP_TURN;
					// (RQ14) master abort without devsel
					end else if (!devsel_s && wait_reg >= hbgp_pkg::DEVSEL_LIMIT) begin
						err_reg   <= 1'b1;
						state_reg <= hbgp_pkg::HBGP_TURN;
					end
				end
				hbgp_pkg::HBGP_TURN: begin
					irdy_out_n   <= 1'b1;
					ad_oe        <= 1'b0;
					cbe_out_n    <= 4'hF;
					cbe_oe       <= 1'b0;
					frame_oe     <= 1'b0;
					irdy_oe      <= 1'b0;
					done_tog_reg <= !done_tog_reg;
					state_reg    <= hbgp_pkg::HBGP_IDLE;
				end
			endcase
		end
	end
	// parity trails address/data by one clock
	always_ff @(posedge clk_link) begin
		if (!link_rst_n_reg) begin
			par_out <= 1'b0;
			par_oe  <= 1'b0;
		end else begin
			par_out <= par_next;
			par_oe  <= ad_oe;
		end
	end
	// (RQ18) never issues locked cycles
	assign lock_out_n = 1'b1;
	assign lock_oe    = 1'b0;
	// (RQ5) no pipelined requests issued
	assign gfx_pipe_n = 1'b1;
	// (RQ6) sideband unused, held idle
	assign gfx_sideband = 8'h00;
	// (RQ10) strobe held idle with sideband
	assign gfx_sideband_strobe = 1'b0;
	// (RQ7) always able to accept read data
	assign gfx_read_full_n = 1'b1;
	// (RQ9) both strobes identical, undriven here
	assign gfx_strobe_a  = 1'b0;
	assign gfx_strobe_b  = 1'b0;
	assign gfx_strobe_oe = 1'b0;
	// (RQ20) bridge reset follows system reset
	assign pci_reset_n = reset_n;
	// checks
	strobe_copies_a: assert property (@(posedge clk_link) gfx_strobe_a == gfx_strobe_b) // (RQ9)
		else $error("strobes differ");
	frame_one_clock_a: assert property ( // (RQ13)
		@(posedge clk_link) disable iff (!link_rst_n_reg)
		!frame_out_n |=> frame_out_n && !irdy_out_n)
		else $error("frame held too long");
	irdy_after_frame_a: assert property ( // (RQ15)
		@(posedge clk_link) disable iff (!link_rst_n_reg)
		$fell(irdy_out_n) |-> !$past(frame_out_n))
		else $error("irdy without address");
	cmd_with_frame_a: assert property ( // (RQ12)
		@(posedge clk_link) disable iff (!link_rst_n_reg)
		!frame_out_n |-> cbe_out_n[3:1] == 3'h3)
		else $error("bad command");
	// even count of ones over last address/data, command and the parity bit
	parity_check_a: assert property ( // (RQ4)
		@(posedge clk_link) disable iff (!link_rst_n_reg)
		par_oe |-> (^{$past(ad_out), $past(cbe_out_n), par_out}) == 1'b0)
		else $error("parity wrong");
	no_lock_a: assert property (@(posedge clk_link) lock_out_n && !lock_oe) // (RQ18)
		else $error("lock driven");
	stop_ends_a: assert property ( // (RQ17)
		@(posedge clk_link) disable iff (!link_rst_n_reg)
		(state_reg == hbgp_pkg::HBGP_DATA && stop_s) |=> state_reg == hbgp_pkg::HBGP_TURN)
		else $error("stop ignored");
	req_before_frame_a: assert property ( // (RQ2)
		@(posedge clk_link) disable iff (!link_rst_n_reg)
		$fell(frame_out_n) |-> !$past(gfx_request_n))
		else $error("frame without request");
endmodule

/* File: tb/hbgp_bridge.sv */
`timescale 1ns/1ps
// bridge-side model: arbiter plus dram target
module hbgp_bridge (
	// clock, reset, test knobs
	input  wire logic        clk_link,
	input  wire logic        reset_n,
	input  wire logic [1:0]  mode,
	input  wire logic [31:0] rd_word,
	// master side pins
	input  wire logic        req_n,
	input  wire logic        frame_n,
	input  wire logic        frame_oe,
	input  wire logic [31:0] ad_out,
	input  wire logic        ad_oe,
	input  wire logic [3:0]  cbe_n,
	input  wire logic        irdy_n,
	input  wire logic        irdy_oe,
	input  wire logic        parity,
	// bridge pins
	output logic             grant_n,
	output logic [2:0]       status,
	output logic [31:0]      ad_in,
	output logic             trdy_n,
	output logic             devsel_n,
	output logic             stop_n,
	// what the bridge saw
	output logic [31:0]      seen_addr,
	output logic [3:0]       seen_cmd,
	output logic [31:0]      seen_wdata,
	output logic             seen_parity
);
	logic       busy;	// transfer claimed
	logic [3:0] phase;	// link clocks since address
	logic       live;	// master still on the bus
	assign live = busy && !(phase > 4'h1 && !irdy_oe);
	// undriven lines show inverted data so stale values cannot pass
	assign ad_in = (!trdy_n && !ad_oe) ? rd_word : ~rd_word;
	// arbiter and target, one process keeps them in step; reset acts at once
	always_ff @(posedge clk_link or negedge reset_n) begin
		if (!reset_n) begin
			grant_n  <= 1'b1;
			status   <= 3'h0;
			busy     <= 1'b0;
			phase    <= 4'h0;
			devsel_n <= 1'b1;
			trdy_n   <= 1'b1;
			stop_n   <= 1'b1;
		end else begin
			// sole grant, status only with it
			grant_n <= req_n;
			status  <= req_n ? 3'h0 : hbgp_pkg::ST_PCI_GRANT;
			// address and command ride with frame
			if (frame_oe && !frame_n && !busy) begin
				busy      <= 1'b1;
				phase     <= 4'h0;
				seen_addr <= ad_out;
				seen_cmd  <= cbe_n;
			end else if (busy && !live) begin
				busy <= 1'b0;
			end else if (busy) begin
				phase <= phase + 4'h1;
			end
			// claim at medium decode, silent mode never claims
			devsel_n <= !(live && mode != 2'h2);
			// ready only in the normal mode
			trdy_n   <= !(live && mode == 2'h0 && phase != 4'h0);
			// stop held until the master lets go
			stop_n   <= !(live && mode == 2'h1 && phase != 4'h0);
			// data taken only when both sides ready
			if (!trdy_n && irdy_oe && !irdy_n) begin
				seen_wdata <= ad_out;
			end
			// parity of the address phase arrives one clock late
			if (busy && phase == 4'h0) begin
				seen_parity <= parity;
			end
		end
	end
endmodule

/* File: tb/tb_hbgp_master.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			bad_count++; \
			$display("unexpected at %0t got %h expected %h", $time, got, exp); \
		end \
	end
module tb_hbgp_master;
	logic        clk_sys = 1'b0, clk_link = 1'b0, reset_n = 1'b0;
	logic        cmd_valid = 1'b0, cmd_write = 1'b0;
	logic [31:0] cmd_addr = 32'h0000_0000, cmd_wdata = 32'h0000_0000;
	logic [31:0] rd_word = 32'h0000_0000;
	logic [1:0]  mode = 2'h0;
	logic        cmd_ready, rsp_valid, rsp_error, gfx_request_n, gfx_grant_n;
	logic [2:0]  gfx_status;
	logic [31:0] rsp_rdata, ad_in, ad_out, seen_addr, seen_wdata, got_data;
	logic [3:0]  cbe_out_n, seen_cmd;
	logic        ad_oe, frame_out_n, frame_oe, irdy_out_n, irdy_oe, trdy_n;
	logic        devsel_n, stop_n, lock_out_n, lock_oe, pci_reset_n;
	logic        got_err, cbe_oe, par_oe, frame_in_n;
	logic        par_out, seen_parity, gfx_pipe_n, gfx_sideband_strobe, gfx_read_full_n;
	logic        gfx_strobe_a, gfx_strobe_b, gfx_strobe_oe;
	logic [7:0]  gfx_sideband;
	int          bad_count = 0, num_checks = 0;
	// two unrelated clocks
	always #5 clk_sys = ~clk_sys;
	always #6 clk_link = ~clk_link;
	// frame wire has a pull-up
	assign frame_in_n = frame_oe ? frame_out_n : 1'b1;
	hbgp_master u_hbgp_master (
		.clk_sys, .reset_n, .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_wdata,
		.rsp_valid, .rsp_rdata, .rsp_error, .clk_link, .gfx_request_n, .gfx_grant_n,
		.gfx_status, .gfx_pipe_n, .gfx_sideband, .gfx_sideband_strobe,
		.gfx_read_full_n, .gfx_strobe_a, .gfx_strobe_b, .gfx_strobe_oe,
		.ad_in, .ad_out, .ad_oe, .cbe_out_n, .cbe_oe, .par_out, .par_oe, .frame_in_n,
		.frame_out_n, .frame_oe, .irdy_out_n, .irdy_oe, .trdy_in_n(trdy_n),
		.devsel_in_n(devsel_n), .stop_in_n(stop_n), .lock_out_n, .lock_oe, .pci_reset_n
	);
	// bridge reset comes from the master's pci reset pin
	hbgp_bridge u_hbgp_bridge (
		.clk_link, .reset_n(pci_reset_n), .mode, .rd_word, .req_n(gfx_request_n),
		.grant_n(gfx_grant_n), .status(gfx_status), .frame_n(frame_out_n), .frame_oe,
		.ad_out, .ad_oe, .cbe_n(cbe_out_n), .irdy_n(irdy_out_n), .irdy_oe, .ad_in,
		.trdy_n, .devsel_n, .stop_n, .seen_addr, .seen_cmd, .seen_wdata,
		.parity(par_out), .seen_parity
	);
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one command through the handshake, waits bounded
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		`CHECK(n < 100, 1'b1)
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// busy master refuses a second command
		`CHECK(cmd_ready, 1'b0)
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge clk_sys);
			n++;
		end
		`CHECK(n < 300, 1'b1)
		got_data = rsp_rdata;
		got_err = rsp_error;
	endtask
	task automatic test_reset;
		`CHECK(pci_reset_n, 1'b0)
		`CHECK({frame_oe, ad_oe, irdy_oe, cbe_oe, par_oe}, 5'h00)
		`CHECK(gfx_pipe_n, 1'b1)
		`CHECK(gfx_sideband, 8'h00)
		`CHECK(gfx_read_full_n, 1'b1)
		`CHECK({gfx_strobe_a, gfx_strobe_oe}, {gfx_strobe_b, 1'b0})
		`CHECK(gfx_sideband_strobe, 1'b0)
		$display("test reset done");
	endtask
	task automatic test_write(input logic [31:0] a, input logic [31:0] d);
		mode = 2'h0;
		xfer(1'b1, a, d);
		`CHECK(got_err, 1'b0)
		`CHECK(seen_addr, a)
		`CHECK(seen_cmd, hbgp_pkg::CMD_MEM_WRITE)
		`CHECK(seen_wdata, d)
		`CHECK(seen_parity, ^{a, hbgp_pkg::CMD_MEM_WRITE})
		`CHECK({lock_oe, lock_out_n}, 2'h1)
		$display("test write done");
	endtask
	task automatic test_read;
		rd_word = 32'h1234_5678;
		xfer(1'b0, 32'h0000_2004, 32'h0000_0000);
		`CHECK(got_err, 1'b0)
		`CHECK(got_data, 32'h1234_5678)
		`CHECK(seen_cmd, hbgp_pkg::CMD_MEM_READ)
		$display("test read done");
	endtask
	task automatic test_stop;
		mode = 2'h1;
		xfer(1'b1, 32'h0000_3008, 32'h0F0F_F0F0);
		`CHECK(got_err, 1'b1)
		`CHECK({frame_oe, irdy_oe}, 2'h0)
		$display("test stop done");
	endtask
	task automatic test_abort;
		mode = 2'h2;
		xfer(1'b0, 32'h0000_400C, 32'h0000_0000);
		`CHECK(got_err, 1'b1)
		`CHECK(gfx_request_n, 1'b1)
		`CHECK(seen_parity, ^{32'h0000_400C, hbgp_pkg::CMD_MEM_READ})
		$display("test abort done");
	endtask
	// main sequence
	initial begin
		repeat (2) @(negedge clk_sys);
		test_reset;
		reset_n = 1'b1;
		repeat (6) @(negedge clk_sys);
		test_write(32'h0000_1000, 32'hA5A5_5A5A);
		test_read;
		test_stop;
		test_abort;
		test_write(32'h0000_5014, 32'h3C3C_C3C3);
		conclude;
	end
	// watchdog, far above five short transfers
	initial begin
		#200000;
		bad_count++;
		conclude;
	end
endmodule
